//--- src/ci_mailbox.sv
// Command channel commands and pump status mailbox, device side.
// Assumes an AXI4-Lite master, a sampled 4-bit command channel input, and
// the arbitration readback and bus-free levels from the surrounding serial bus logic.
// Behaviour
// - Bypass mode accepts no pump control commands
// - Arbitration off: send fixed code continuously
// - Arbitration on: fixed code only when idle, free, lowest
// - Another owner gains bus: send all ones
// - Command 9N stores code sent when granted
// - Access needs address readback match and free bit
// - Received code changes reach host in order
// - Command A0 forwards current code regardless
// - Received code valid after three identical samples
// - Datapath select 01 path one, 10 two
// - Path mode field uses documented three-bit codes
// - Rate index reports current fax rate code
// - Modulation index zero means setup failed
// - Fax modulation codes 21h, 27h, 28h, 2Ch
//
// Our own choices: register access over AXI4-Lite and the address map.
module ci_mailbox
  import ci_mailbox_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Command channel and arbitration pins
  input wire logic [3:0] channel_rx,
  output logic [3:0] channel_command_code,
  input wire logic bus_free_bit,
  input wire logic [2:0] arbitration_readback,
  output logic [2:0] arbitration_address,
  // Interrupt
  output logic irq
);
  import ci_mailbox_pkg::*;
  localparam int AW = $clog2(FIFO_DEPTH);

  // Register state
  logic [7:0] host_message_status;
  logic [15:0] mailbox_control_word;
  response_s response;
  logic [3:0] fixed_code;
  logic [3:0] arb_code;
  logic arbitrated_bus_enable;
  logic channel_enable_bit;
  logic [2:0] path_mode;
  logic [1:0] originate_answer_field;
  logic [7:0] rate_index_low;
  logic [7:0] modulation_index;
  logic access_request;
  logic access_granted;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;

  // Bus handshake state
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Pin synchronisers
  logic [3:0] rx_s1, rx_s2, rx_s3;
  logic free_s1, free_s2, free_s3;
  logic [2:0] rb_s1, rb_s2, rb_s3;
  logic [3:0] rx_prev;
  logic [3:0] rx_valid;
  logic free_level;
  logic [2:0] rb_level;

  // Received code queue
  logic [3:0] fifo_mem [FIFO_DEPTH];
  logic [AW:0] wr_ptr, rd_ptr;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction : hit

  // Write path decode
  wire aw_ok = s_axi_awvalid && !aw_held;
  wire w_ok = s_axi_wvalid && !w_held;
  wire [7:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
  wire have_aw = aw_held || s_axi_awvalid;
  wire have_w = w_held || s_axi_wvalid;
  wire do_write = have_aw && have_w && !s_axi_bvalid;
  wire wr_host = do_write && hit(wa, OFF_HOST_MSG) && ws[0];
  wire wr_ctrl = do_write && hit(wa, OFF_CTRL_WORD);
  wire wr_config = do_write && hit(wa, OFF_CONFIG) && ws[0];
  wire wr_pump = do_write && hit(wa, OFF_PUMP);
  wire wr_irq = do_write && hit(wa, OFF_IRQ_STATUS) && ws[0];
  wire wr_mask = do_write && hit(wa, OFF_IRQ_MASK) && ws[0];
  wire wr_arb = do_write && hit(wa, OFF_ARB) && ws[0];
  wire wr_known = hit(wa, OFF_HOST_MSG) || hit(wa, OFF_CTRL_WORD) || hit(wa, OFF_CONFIG)
    || hit(wa, OFF_PUMP) || hit(wa, OFF_IRQ_STATUS) || hit(wa, OFF_IRQ_MASK)
    || hit(wa, OFF_ARB);

  // Command decode: host message byte starts a command using the held control word
  wire [5:0] msg_class = wd[5:0];
  wire [1:0] msg_path = wd[7:6];
  wire path_ok = (msg_path == DPS_PATH1) || (msg_path == DPS_PATH2);
  wire [7:0] cmd = mailbox_control_word[15:8];
  wire is_channel_cmd = wr_host && msg_class == CLASS_CTRL_CHANNEL && path_ok
    && path_mode != PATH_MODE_FIELD_BYPASS;
  wire bypass_reject = wr_host && msg_class == CLASS_CTRL_BYPASS && path_mode == PATH_MODE_FIELD_BYPASS;
  wire is_status_req = wr_host && msg_class == CLASS_STATUS_REQ && path_ok
    && mailbox_control_word == 16'h0000;
  wire bad_status_req = wr_host && msg_class == CLASS_STATUS_REQ
    && !(path_ok && mailbox_control_word == 16'h0000);
  wire set_fixed = is_channel_cmd && cmd[7:4] == CMD_FIXED;
  wire set_arb = is_channel_cmd && cmd[7:4] == CMD_ARB;
  wire read_code = is_channel_cmd && cmd == CMD_READ_CODE;

  // Access succeeds only when the read-back address matches and bus is free
  wire access_ok = access_request && rb_level == arbitration_address && free_level;

  // Transmit code selection
  wire idle_lowest = !access_request && free_level && arbitration_address == ADDR_LOWEST;
  wire [3:0] tx_arb = access_granted ? arb_code
    : idle_lowest ? fixed_code : CODE_IDLE;
  wire [3:0] tx_code = !channel_enable_bit ? CODE_IDLE
    : arbitrated_bus_enable ? tx_arb : fixed_code;

  // Received code: double last look and change detection
  wire rx_stable = rx_s3 == rx_s2 && rx_s2 == rx_prev;
  wire rx_change = rx_stable && rx_s3 != rx_valid;
  wire push_code = channel_enable_bit && (rx_change || read_code);
  wire [3:0] push_value = rx_stable ? rx_s3 : rx_valid;
  wire fifo_full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire fifo_empty = wr_ptr == rd_ptr;
  wire do_push = push_code && !fifo_full;

  // Read path
  wire do_read = s_axi_arvalid && !s_axi_rvalid;
  wire pop_code = do_read && hit(s_axi_araddr, OFF_CODE_FIFO) && !fifo_empty;
  wire [AW-1:0] rd_idx = rd_ptr[AW-1:0];
  logic [31:0] rd_mux;
  logic rd_known;
  always_comb
  begin
    rd_known = 1'b1;
    unique case (s_axi_araddr[7:2])
      OFF_CTRL_WORD[7:2]: rd_mux = {16'h0000, mailbox_control_word};
      OFF_DEV_MSG[7:2]: rd_mux = {24'h00_0000, response.msg};
      OFF_DEV_CTRL[7:2]: rd_mux = {16'h0000, response.ctrl};
      OFF_DEV_PARAM[7:2]: rd_mux = {16'h0000, response.modulation, response.rate};
      OFF_CONFIG[7:2]: rd_mux = {30'h0000_0000, channel_enable_bit, arbitrated_bus_enable};
      OFF_PUMP[7:2]: rd_mux = {3'b000, path_mode, originate_answer_field,
        modulation_index, rate_index_low, 8'h00};
      OFF_IRQ_STATUS[7:2]: rd_mux = {29'h0000_0000, irq_status};
      OFF_IRQ_MASK[7:2]: rd_mux = {29'h0000_0000, irq_mask};
      OFF_CODE_FIFO[7:2]: rd_mux = {23'h00_0000, !fifo_empty, 4'h0,
        fifo_empty ? 4'h0 : fifo_mem[rd_idx]};
      OFF_ARB[7:2]: rd_mux = {24'h00_0000, access_granted, access_request, free_level,
        2'b00, arbitration_address};
      default:
      begin
        rd_mux = 32'h0000_0000;
        rd_known = 1'b0;
      end
    endcase
  end

  // Interrupt events
  wire [2:0] irq_event = {bypass_reject || bad_status_req, do_push, is_status_req};
  assign irq = |(irq_status & irq_mask);
  assign s_axi_awready = aw_ok;
  assign s_axi_wready = w_ok;

  // Response assembly: fax layout with the current pump state
  wire [7:0] rsp_msg = {msg_path, CLASS_STATUS_RSP};
  wire [15:0] rsp_ctrl = {originate_answer_field, 3'b000, path_mode,
    STATUS_PARAM_COUNT};
  wire [7:0] rsp_mod = path_mode == PATH_MODE_FIELD_DISABLE ? MOD_NONE : modulation_index;
  wire [7:0] rsp_rate = rsp_mod == MOD_NONE ? RATE_NONE : rate_index_low;

  // Bus handshake registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (aw_ok)
        aw_addr <= s_axi_awaddr;
      if (w_ok)
      begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      aw_held <= do_write ? 1'b0 : (aw_held || s_axi_awvalid);
      w_held <= do_write ? 1'b0 : (w_held || s_axi_wvalid);
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_read)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_known ? 2'b00 : 2'b10;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  assign s_axi_arready = do_read;

  // Configuration, commands and responses
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      host_message_status <= 8'h00;
      mailbox_control_word <= 16'h0000;
      response <= '0;
      fixed_code <= CODE_IDLE;
      arb_code <= CODE_IDLE;
      arbitrated_bus_enable <= 1'b0;
      channel_enable_bit <= 1'b0;
      path_mode <= PATH_MODE_FIELD_DISABLE;
      originate_answer_field <= 2'b00;
      rate_index_low <= RATE_NONE;
      modulation_index <= MOD_NONE;
      access_request <= 1'b0;
      access_granted <= 1'b0;
      arbitration_address <= ADDR_LOWEST;
      irq_mask <= IRQ_RESET;
      irq_status <= IRQ_RESET;
      channel_command_code <= CODE_IDLE;
    end
    else
    begin
      if (wr_host)
        host_message_status <= wd[7:0];
      if (wr_ctrl && ws[0])
        mailbox_control_word[7:0] <= wd[7:0];
      if (wr_ctrl && ws[1])
        mailbox_control_word[15:8] <= wd[15:8];
      if (set_fixed)
        fixed_code <= cmd[3:0];
      if (set_arb)
        arb_code <= cmd[3:0];
      if (wr_config)
      begin
        arbitrated_bus_enable <= wd[0];
        channel_enable_bit <= wd[1];
      end
      if (wr_pump)
      begin
        if (ws[1])
          rate_index_low <= wd[15:8];
        if (ws[2])
          modulation_index <= wd[23:16];
        if (ws[3])
        begin
          originate_answer_field <= wd[25:24];
          path_mode <= wd[28:26];
        end
      end
      if (is_status_req)
      begin
        response.msg <= rsp_msg;
        response.ctrl <= rsp_ctrl;
        response.rate <= rsp_rate;
        response.modulation <= rsp_mod;
      end
      if (wr_arb)
      begin
        arbitration_address <= wd[2:0];
        access_request <= wd[6];
      end
      access_granted <= arbitrated_bus_enable && access_ok;
      irq_mask <= wr_mask ? wd[2:0] : irq_mask;
      irq_status <= (irq_status & ~(wr_irq ? wd[2:0] : 3'b000)) | irq_event;
      channel_command_code <= tx_code;
    end
  end

  // Pin synchronisers and received code tracking
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_s1 <= CODE_IDLE;
      rx_s2 <= CODE_IDLE;
      rx_s3 <= CODE_IDLE;
      rx_prev <= CODE_IDLE;
      rx_valid <= CODE_IDLE;
      free_s1 <= 1'b0;
      free_s2 <= 1'b0;
      free_s3 <= 1'b0;
      free_level <= 1'b0;
      rb_s1 <= 3'b000;
      rb_s2 <= 3'b000;
      rb_s3 <= 3'b000;
      rb_level <= 3'b000;
    end
    else
    begin
      rx_s1 <= channel_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      rx_prev <= rx_s3;
      if (rx_stable)
        rx_valid <= rx_s3;
      free_s1 <= bus_free_bit;
      free_s2 <= free_s1;
      free_s3 <= free_s2;
      if (free_s2 == free_s3)
        free_level <= free_s3;
      rb_s1 <= arbitration_readback;
      rb_s2 <= rb_s1;
      rb_s3 <= rb_s2;
      if (rb_s2 == rb_s3)
        rb_level <= rb_s3;
    end
  end

  // Received code queue, oldest first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      if (do_push)
      begin
        fifo_mem[wr_ptr[AW-1:0]] <= push_value;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop_code)
        rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule : ci_mailbox

//--- src/ci_mailbox_pkg.sv
// Package for the command channel and pump status mailbox block.
// Assumes a single 200 MHz clock and an AXI4-Lite register master.
package ci_mailbox_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_HOST_MSG = 8'h00;
  localparam logic [7:0] OFF_CTRL_WORD = 8'h04;
  localparam logic [7:0] OFF_DEV_MSG = 8'h08;
  localparam logic [7:0] OFF_DEV_CTRL = 8'h0C;
  localparam logic [7:0] OFF_DEV_PARAM = 8'h10;
  localparam logic [7:0] OFF_CONFIG = 8'h14;
  localparam logic [7:0] OFF_PUMP = 8'h18;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
  localparam logic [7:0] OFF_CODE_FIFO = 8'h24;
  localparam logic [7:0] OFF_ARB = 8'h28;
  // Host message status fields
  localparam int DPS_POS = 6;
  localparam logic [5:0] CLASS_CTRL_CHANNEL = 6'h2A;
  localparam logic [5:0] CLASS_CTRL_BYPASS = 6'h2A;
  localparam logic [5:0] CLASS_STATUS_REQ = 6'h0E;
  localparam logic [5:0] CLASS_STATUS_RSP = 6'h2E;
  localparam logic [1:0] DPS_PATH1 = 2'b01;
  localparam logic [1:0] DPS_PATH2 = 2'b10;
  // Channel commands (upper nibble; A0 whole byte), idle code and lowest address
  localparam logic [3:0] CMD_FIXED = 4'h8;
  localparam logic [3:0] CMD_ARB = 4'h9;
  localparam logic [7:0] CMD_READ_CODE = 8'hA0;
  localparam logic [3:0] CODE_IDLE = 4'hF;
  localparam logic [2:0] ADDR_LOWEST = 3'b111;
  // Path modes
  localparam logic [2:0] PATH_MODE_FIELD_DISABLE = 3'b000;
  localparam logic [2:0] PATH_MODE_FIELD_FAX = 3'b001;
  localparam logic [2:0] PATH_MODE_FIELD_DATAMODEM = 3'b010;
  localparam logic [2:0] PATH_MODE_FIELD_HALFDUPLEX = 3'b011;
  localparam logic [2:0] PATH_MODE_FIELD_V110 = 3'b100;
  localparam logic [2:0] PATH_MODE_FIELD_DTMF = 3'b101;
  localparam logic [2:0] PATH_MODE_FIELD_BYPASS = 3'b111;
  // Fax rate and modulation codes
  localparam logic [7:0] RATE_NONE = 8'h00;
  localparam logic [7:0] RATE_300 = 8'h02;
  localparam logic [7:0] RATE_2400 = 8'h05;
  localparam logic [7:0] RATE_9600 = 8'h08;
  localparam logic [7:0] RATE_12000 = 8'h09;
  localparam logic [7:0] RATE_14400 = 8'h0A;
  localparam logic [7:0] MOD_NONE = 8'h00;
  localparam logic [7:0] MOD_V21 = 8'h21;
  localparam logic [7:0] MOD_V17 = 8'h27;
  localparam logic [7:0] MOD_V29 = 8'h28;
  localparam logic [7:0] MOD_V27TER = 8'h2C;
  localparam logic [7:0] STATUS_PARAM_COUNT = 8'h02;
  // Interrupt bits
  localparam int IRQ_RESPONSE = 0;
  localparam int IRQ_CODE = 1;
  localparam int IRQ_REJECT = 2;
  localparam logic [2:0] IRQ_RESET = 3'b000;

  typedef struct packed {
    logic [7:0] msg;
    logic [15:0] ctrl;
    logic [7:0] rate;
    logic [7:0] modulation;
  } response_s;
endpackage : ci_mailbox_pkg

//--- testbench/ci_mailbox_assertions.sv
// Port checker for the command channel and pump status mailbox.
// Assumes one clock domain and a bind onto ci_mailbox.
module ci_mailbox_assertions
  import ci_mailbox_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
)(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Channel side
  input wire logic [3:0] channel_command_code,
  input wire logic [2:0] arbitration_address
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write not answered next cycle");
  AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  AST_ONE_READ: assert property (rd_taken |-> !s_axi_rvalid)
    else $error("read taken while answer pending");
  AST_REFUSED_ZERO: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read returns data");
  AST_ADDR_BY_WRITE: assert property (!$stable(arbitration_address) |-> s_axi_bvalid)
    else $error("bus address moved without a write");
  AST_IDLE_AT_RELEASE: assert property ($rose(aresetn) |-> channel_command_code == CODE_IDLE && arbitration_address == ADDR_LOWEST)
    else $error("channel not idle after reset");
endmodule : ci_mailbox_assertions

bind ci_mailbox ci_mailbox_assertions #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .channel_command_code, .arbitration_address);

//--- testbench/far_bus_model.sv
// Far side: serial bus peers and the received command channel.
// Assumes the bench steers the received code, bus-free level and readback fault.
module far_bus_model (
  // Clock
  input wire logic aclk,
  // Steering
  input wire logic [3:0] rx_code,
  input wire logic free,
  input wire logic bad_readback,
  // Device pins
  input wire logic [2:0] arbitration_address,
  output logic [3:0] channel_rx,
  output logic bus_free_bit,
  output logic [2:0] arbitration_readback
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge aclk)
  begin
    channel_rx <= rx_code;
    // Low while another device holds the bus
    bus_free_bit <= free;
    // Address echo, corrupted on demand
    arbitration_readback <= bad_readback ? ~arbitration_address : arbitration_address;
  end
endmodule : far_bus_model

//--- testbench/ci_mailbox_tb.sv
// Bench for the command channel and pump status mailbox.
// Assumes far_bus_model at the channel pins and the bound port checker.
module ci_mailbox_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ci_mailbox_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic [31:0] s_axi_rdata, rd_data;
  logic [3:0] channel_rx, channel_command_code;
  logic [2:0] arbitration_readback, arbitration_address;
  logic bus_free_bit;
  logic [3:0] rx_code = 4'hF;
  logic free = 1'b1;
  logic bad_readback = 1'b0;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;

  ci_mailbox #(.FIFO_DEPTH(8)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .channel_rx, .channel_command_code,
    .bus_free_bit, .arbitration_readback, .arbitration_address, .irq);
  far_bus_model i_far (.aclk, .rx_code, .free, .bad_readback, .arbitration_address,
    .channel_rx, .bus_free_bit, .arbitration_readback);

  initial
  begin
    forever #2.5 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches++;
      results();
    end
  end

  task automatic results();
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
      begin
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      s_axi_bready <= s_axi_bvalid;
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready)
      begin
        rd_data = s_axi_rdata;
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      s_axi_rready <= s_axi_rvalid;
    end
  endtask : rd

  task automatic cmd(input logic [7:0] c);
    wr(OFF_CTRL_WORD, {16'h0000, c, 8'h00});
    wr(OFF_HOST_MSG, {24'h00_0000, DPS_PATH1, CLASS_CTRL_CHANNEL});
  endtask : cmd

  task automatic code_is(input logic [3:0] exp);
    repeat (12) @(posedge aclk);
    chk({28'h000_0000, channel_command_code}, {28'h000_0000, exp}, "channel code");
  endtask : code_is

  task automatic t_fixed();
    cmd(8'h85);
    cmd(8'h93);
    wr(OFF_CONFIG, 32'h0000_0002);
    free <= 1'b0;
    code_is(4'h5);
  endtask : t_fixed

  task automatic t_arb();
    wr(OFF_CONFIG, 32'h0000_0003);
    code_is(4'hF);
    free <= 1'b1;
    code_is(4'h5);
    free <= 1'b0;
    code_is(4'hF);
    free <= 1'b1;
    wr(OFF_ARB, 32'h0000_0042);
    code_is(4'h3);
    chk({29'h0000_0000, arbitration_address}, 32'h0000_0002, "driven address");
    rd(OFF_ARB);
    chk({29'h0000_0000, rd_data[7:5]}, 32'h0000_0007, "grant flags");
    bad_readback <= 1'b1;
    code_is(4'hF);
    bad_readback <= 1'b0;
    wr(OFF_ARB, 32'h0000_0007);
    code_is(4'h5);
  endtask : t_arb

  task automatic t_queue();
    logic [3:0] q[3] = '{4'hC, 4'h7, 4'h7};
    repeat (9) rd(OFF_CODE_FIFO);
    wr(OFF_IRQ_STATUS, 32'h0000_0002);
    wr(OFF_IRQ_MASK, 32'h0000_0002);
    rx_code <= 4'hC;
    repeat (12) @(posedge aclk);
    chk({31'h0000_0000, irq}, 32'h0000_0001, "code irq");
    rx_code <= 4'h3;
    @(posedge aclk);
    rx_code <= 4'hC;
    repeat (12) @(posedge aclk);
    rx_code <= 4'h7;
    repeat (12) @(posedge aclk);
    cmd(CMD_READ_CODE);
    repeat (12) @(posedge aclk);
    foreach (q[i])
    begin
      rd(OFF_CODE_FIFO);
      chk({23'h00_0000, rd_data[8:0]}, {23'h00_0000, 1'b1, 4'h0, q[i]}, "queued code");
    end
    rd(OFF_CODE_FIFO);
    chk({31'h0000_0000, rd_data[8]}, 32'h0000_0000, "glitch queued");
    wr(OFF_IRQ_STATUS, 32'h0000_0002);
    chk({31'h0000_0000, irq}, 32'h0000_0000, "irq cleared");
  endtask : t_queue

  task automatic t_status();
    logic [2:0] pm[5] = '{3'b001, 3'b001, 3'b010, 3'b011, 3'b000};
    logic [7:0] md[5] = '{MOD_V21, MOD_V17, MOD_V29, MOD_V27TER, MOD_V21};
    logic [7:0] rt[5] = '{RATE_300, RATE_14400, RATE_9600, RATE_2400, RATE_300};
    logic [1:0] dp;
    logic [7:0] em, er;
    wr(OFF_IRQ_MASK, 32'h0000_0001);
    for (int i = 0; i < 5; i++)
    begin
      dp = i[0] ? DPS_PATH2 : DPS_PATH1;
      em = (pm[i] == PATH_MODE_FIELD_DISABLE) ? MOD_NONE : md[i];
      er = (em == MOD_NONE) ? RATE_NONE : rt[i];
      wr(OFF_PUMP, {3'b000, pm[i], i[1:0], md[i], rt[i], 8'h00});
      wr(OFF_CTRL_WORD, 32'h0000_0000);
      wr(OFF_HOST_MSG, {24'h00_0000, dp, CLASS_STATUS_REQ});
      rd(OFF_DEV_MSG);
      chk({24'h00_0000, rd_data[7:0]}, {24'h00_0000, dp, CLASS_STATUS_RSP}, "tag");
      rd(OFF_DEV_CTRL);
      chk({16'h0000, rd_data[15:0]}, {16'h0000, i[1:0], 3'b000, pm[i], STATUS_PARAM_COUNT}, "mode");
      rd(OFF_DEV_PARAM);
      chk({16'h0000, rd_data[15:0]}, {16'h0000, em, er}, "rate");
      chk({31'h0000_0000, irq}, 32'h0000_0001, "response irq");
      wr(OFF_IRQ_STATUS, 32'h0000_0001);
      chk({31'h0000_0000, irq}, 32'h0000_0000, "single response");
    end
  endtask : t_status

  task automatic t_bypass();
    wr(OFF_IRQ_MASK, 32'h0000_0004);
    wr(OFF_PUMP, 32'h1C00_0000);
    cmd(8'h8A);
    code_is(4'h5);
    rd(OFF_IRQ_STATUS);
    chk({31'h0000_0000, rd_data[2]}, 32'h0000_0001, "refusal flag");
    chk({31'h0000_0000, irq}, 32'h0000_0001, "refusal irq");
    wr(OFF_IRQ_STATUS, 32'h0000_0004);
    chk({31'h0000_0000, irq}, 32'h0000_0000, "refusal cleared");
    rd(8'hFC);
    chk({30'h0000_0000, rd_resp}, 32'h0000_0002, "unmapped resp");
    chk(rd_data, 32'h0000_0000, "unmapped data");
    wr(8'hFC, 32'h0000_0000);
    chk({30'h0000_0000, wr_resp}, 32'h0000_0002, "unmapped write resp");
  endtask : t_bypass

  initial
  begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_fixed();
    t_arb();
    t_queue();
    t_status();
    t_bypass();
    results();
  end
endmodule : ci_mailbox_tb
